//--- tcb_consts.svh
`ifndef TCB_CONSTS_SVH
`define TCB_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TCB_ADDR_FIRST_CNT 8'h10
`define TCB_ADDR_SECOND_CNT 8'h11
`define TCB_ADDR_FIRST_PER 8'h12
`define TCB_ADDR_SECOND_PER 8'h13
`define TCB_ADDR_WIDE_LO 8'h14
`define TCB_ADDR_WIDE_HI 8'h15
`define TCB_ADDR_CTRL 8'h16
`define TCB_ADDR_CTRL2 8'h17
`define TCB_ADDR_PCA_LO 8'h18
`define TCB_ADDR_PCA_HI 8'h19
`define TCB_ADDR_CAPB_LO 8'h1a
`define TCB_ADDR_CAPB_HI 8'h1b
`define TCB_ADDR_STATUS 8'h1c
`define TCB_ADDR_MASK 8'h1d

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define TCB_CTRL_FIRST_SRC 0
`define TCB_CTRL_SECOND_SRC 1
`define TCB_CTRL_WIDE_SRC 2
`define TCB_CTRL_CASCADE 3
`define TCB_CTRL_CAPA_LSB 4
`define TCB_CTRL_CAPB_LSB 6
`define TCB_CTRL2_SEL 0
`define TCB_CTRL2_OVR_LSB 4
`define TCB_ST_FIRST 0
`define TCB_ST_SECOND 1
`define TCB_ST_WIDE 2
`define TCB_ST_CAPA 3
`define TCB_ST_CAPB 4
`define TCB_ST_W 5
`define TCB_CTRL_RST 8'h00
`define TCB_PER8_RST 8'hff
`define TCB_PER16_RST 16'hffff
`define TCB_PRE_LAST4 4'h3
`define TCB_PRE_LAST16 4'hf

`endif

//--- tcb_pkg.sv
package tcb_pkg;

	typedef enum logic [1:0]
	{
		TCB_EDGE_FALL = 2'b00,
		TCB_EDGE_RISE = 2'b01,
		TCB_EDGE_RISE4 = 2'b10,
		TCB_EDGE_RISE16 = 2'b11
	} tcb_edge_mode_t;

endpackage : tcb_pkg

//--- tcb_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcb_consts.svh"

module tcb_edge_det
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic pin_in,
	input wire logic [1:0] mode_in,
	output logic event_out
);

	// ----------------------------------------------------------------
	// synchroniser and edge detect
	// ----------------------------------------------------------------
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;
	logic [3:0] pre_reg;
	logic rise;
	logic fall;
	tcb_pkg::tcb_edge_mode_t mode;

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		// pins idle high: a low reset value would fake a rising edge
		// after reset and nudge the prescaler one step ahead
		if (!nrst_in)
		begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			prev_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= pin_in; // R18
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign rise = sync_reg & ~prev_reg;
	assign fall = prev_reg & ~sync_reg;

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	// a mode change leaves the count alone, so the first event after
	// a change may come early
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			pre_reg <= 4'h0; // R16
		else if (rise)
			pre_reg <= pre_reg + 4'h1;
	end

	always_comb
	begin
		mode = tcb_pkg::tcb_edge_mode_t'(mode_in);
		unique case (mode)
			tcb_pkg::TCB_EDGE_FALL: event_out = fall;
			tcb_pkg::TCB_EDGE_RISE: event_out = rise;
			tcb_pkg::TCB_EDGE_RISE4:
				event_out = rise & (pre_reg[1:0] == `TCB_PRE_LAST4);
			tcb_pkg::TCB_EDGE_RISE16:
				event_out = rise & (pre_reg == `TCB_PRE_LAST16);
		endcase
	end

endmodule : tcb_edge_det
`default_nettype wire

//--- tcb_timer_top.sv
// Functional notes
// R01: two independent 8-bit up timers, each with period and overflow flag.
// R02: timers count internal clock, or falling edges of shared clock pin.
// R03: control bit 0 picks first timer source: 1 pin, 0 internal.
// R04: control bit 1 picks second timer source: 1 pin, 0 internal.
// R05: control bit 2 picks wide timer source: own pin or internal.
// R06: control bit 3 cascades both 8-bit timers into one 16-bit timer.
// R07: wide timer is 16 bits, read and written as two bytes.
// R08: shared pair is wide period register or first capture register.
// R09: second capture has own pair; both capture the wide count.
// R10: control bits 7-6 pick second capture edge: fall, rise, 4th, 16th.
// R11: control bits 5-4 pick first capture edge, same encoding.
// R12: wide timer source is software selectable, internal or pin.
// R13: in period mode wide timer wraps at period and sets its flag.
// R14: with select bit clear, first capture is off and never flags.
// R15: event on unread capture keeps it, sets pending overrun, shown later.
// R16: edge mode change keeps prescaler; only reset clears it.
// R17: timers wrap to zero after matching period and set overflow flag.
// R18: external inputs are synchronised before edges are detected.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tcb_consts.svh"

module tcb_timer_top
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic shared_ext_clock_pin_in,
	input wire logic wide_ext_clock_pin_in,
	input wire logic [1:0] cap_pin_in,
	output logic irq_out
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] ctrl_reg;
	logic sel_reg;
	logic [7:0] first_cnt_reg;
	logic [7:0] second_cnt_reg;
	logic [7:0] first_per_reg;
	logic [7:0] second_per_reg;
	logic [15:0] wide_cnt_reg;
	logic [15:0] pc_reg [0:1];
	logic [1:0] full_reg;
	logic [1:0] pend_reg;
	logic [1:0] ovr_reg;
	logic [1:0] lo_rd_reg;
	logic [1:0] hi_rd_reg;
	logic [`TCB_ST_W-1:0] status_reg;
	logic [`TCB_ST_W-1:0] mask_reg;
	logic [`TCB_ST_W-1:0] status_next;
	logic [`TCB_ST_W-1:0] ev;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	logic shared_fall;
	logic wide_fall;
	logic first_tick;
	logic second_tick;
	logic wide_tick;
	logic cascade;
	logic first_hit;
	logic second_hit;
	logic casc_hit;
	logic wide_hit;
	logic wide_top;
	logic [1:0] cap_ev;
	logic [1:0] cap_take;
	logic [1:0] cap_done;

	// ----------------------------------------------------------------
	// clock sources
	// ----------------------------------------------------------------
	// clk_in is the instruction clock, already a quarter of the oscillator
	tcb_edge_det u_shared_clk
	(
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.pin_in(shared_ext_clock_pin_in),
		.mode_in(tcb_pkg::TCB_EDGE_FALL),
		.event_out(shared_fall)
	);

	tcb_edge_det u_wide_clk
	(
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.pin_in(wide_ext_clock_pin_in),
		.mode_in(tcb_pkg::TCB_EDGE_FALL),
		.event_out(wide_fall)
	);

	assign first_tick = ctrl_reg[`TCB_CTRL_FIRST_SRC] ? shared_fall : 1'b1; // R03
	assign second_tick = ctrl_reg[`TCB_CTRL_SECOND_SRC] ? shared_fall : 1'b1; // R04
	assign wide_tick = ctrl_reg[`TCB_CTRL_WIDE_SRC] ? wide_fall : 1'b1; // R05
	assign cascade = ctrl_reg[`TCB_CTRL_CASCADE]; // R06

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ctrl_reg <= `TCB_CTRL_RST;
			sel_reg <= 1'b0;
			mask_reg <= '0;
			first_per_reg <= `TCB_PER8_RST;
			second_per_reg <= `TCB_PER8_RST;
		end
		else if (wr_in)
		begin
			if (addr_in == `TCB_ADDR_CTRL)
				ctrl_reg <= wdata_in;
			if (addr_in == `TCB_ADDR_CTRL2)
				sel_reg <= wdata_in[`TCB_CTRL2_SEL];
			if (addr_in == `TCB_ADDR_MASK)
				mask_reg <= wdata_in[`TCB_ST_W-1:0];
			if (addr_in == `TCB_ADDR_FIRST_PER)
				first_per_reg <= wdata_in;
			if (addr_in == `TCB_ADDR_SECOND_PER)
				second_per_reg <= wdata_in;
		end
	end

	// ----------------------------------------------------------------
	// 8-bit timers and cascade
	// ----------------------------------------------------------------
	assign first_hit = first_cnt_reg == first_per_reg;
	assign second_hit = second_cnt_reg == second_per_reg;
	assign casc_hit = first_hit & second_hit;

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			first_cnt_reg <= 8'h00;
		else if (wr_in && addr_in == `TCB_ADDR_FIRST_CNT)
			first_cnt_reg <= wdata_in;
		else if (first_tick)
		begin
			if (cascade ? casc_hit : first_hit) // R17
				first_cnt_reg <= 8'h00;
			else
				first_cnt_reg <= first_cnt_reg + 8'h01; // R01
		end
	end

	// in cascade mode the high half follows the first timer's source
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			second_cnt_reg <= 8'h00;
		else if (wr_in && addr_in == `TCB_ADDR_SECOND_CNT)
			second_cnt_reg <= wdata_in;
		else if (cascade)
		begin
			if (first_tick && casc_hit) // R06
				second_cnt_reg <= 8'h00;
			else if (first_tick && first_cnt_reg == 8'hff)
				second_cnt_reg <= second_cnt_reg + 8'h01;
		end
		else if (second_tick)
		begin
			if (second_hit) // R17
				second_cnt_reg <= 8'h00;
			else
				second_cnt_reg <= second_cnt_reg + 8'h01; // R01
		end
	end

	// ----------------------------------------------------------------
	// wide timer
	// ----------------------------------------------------------------
	assign wide_hit = wide_cnt_reg == pc_reg[0];
	assign wide_top = wide_cnt_reg == 16'hffff;

	// a byte write wins over a tick; the other byte is left as it was
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			wide_cnt_reg <= 16'h0000;
		else if (wr_in && addr_in == `TCB_ADDR_WIDE_LO)
			wide_cnt_reg[7:0] <= wdata_in; // R07
		else if (wr_in && addr_in == `TCB_ADDR_WIDE_HI)
			wide_cnt_reg[15:8] <= wdata_in; // R07
		else if (wide_tick) // R12
		begin
			if (!sel_reg && wide_hit) // R13
				wide_cnt_reg <= 16'h0000;
			else
				wide_cnt_reg <= wide_cnt_reg + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// captures
	// ----------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_cap
			localparam logic [7:0] LO = (ch == 0) ? `TCB_ADDR_PCA_LO :
				`TCB_ADDR_CAPB_LO;
			localparam logic [7:0] HI = (ch == 0) ? `TCB_ADDR_PCA_HI :
				`TCB_ADDR_CAPB_HI;
			localparam int MSB = (ch == 0) ? `TCB_CTRL_CAPA_LSB + 1 :
				`TCB_CTRL_CAPB_LSB + 1;
			logic active;
			logic rd_lo;
			logic rd_hi;

			tcb_edge_det u_cap
			(
				.clk_in(clk_in),
				.nrst_in(nrst_in),
				.pin_in(cap_pin_in[ch]),
				.mode_in(ctrl_reg[MSB -: 2]), // R10 R11
				.event_out(cap_ev[ch])
			);

			assign active = (ch == 0) ? sel_reg : 1'b1; // R14 R08
			assign rd_lo = active && rd_in && addr_in == LO;
			assign rd_hi = active && rd_in && addr_in == HI;
			assign cap_done[ch] = full_reg[ch] && (lo_rd_reg[ch] || rd_lo) &&
				(hi_rd_reg[ch] || rd_hi);
			// completing the read frees the slot in the same cycle
			assign cap_take[ch] = active && cap_ev[ch] &&
				(!full_reg[ch] || cap_done[ch]);

			always_ff @(posedge clk_in or negedge nrst_in)
			begin
				if (!nrst_in)
					pc_reg[ch] <= `TCB_PER16_RST;
				else if (cap_take[ch])
					pc_reg[ch] <= wide_cnt_reg; // R09
				else if (wr_in && addr_in == LO)
					pc_reg[ch][7:0] <= wdata_in; // R08
				else if (wr_in && addr_in == HI)
					pc_reg[ch][15:8] <= wdata_in;
			end

			always_ff @(posedge clk_in or negedge nrst_in)
			begin
				if (!nrst_in)
				begin
					full_reg[ch] <= 1'b0;
					lo_rd_reg[ch] <= 1'b0;
					hi_rd_reg[ch] <= 1'b0;
				end
				else if (cap_done[ch] || cap_take[ch])
				begin
					full_reg[ch] <= cap_take[ch];
					lo_rd_reg[ch] <= 1'b0;
					hi_rd_reg[ch] <= 1'b0;
				end
				else if (full_reg[ch])
				begin
					lo_rd_reg[ch] <= lo_rd_reg[ch] | rd_lo;
					hi_rd_reg[ch] <= hi_rd_reg[ch] | rd_hi;
				end
			end

			// pending bit moves to the visible flag when both bytes are read
			always_ff @(posedge clk_in or negedge nrst_in)
			begin
				if (!nrst_in)
				begin
					pend_reg[ch] <= 1'b0;
					ovr_reg[ch] <= 1'b0;
				end
				else if (cap_done[ch])
				begin
					pend_reg[ch] <= 1'b0; // R15
					ovr_reg[ch] <= pend_reg[ch];
				end
				else if (active && cap_ev[ch] && full_reg[ch])
					pend_reg[ch] <= 1'b1; // R15
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------
	always_comb
	begin
		ev = '0;
		ev[`TCB_ST_FIRST] = first_tick && (cascade ? casc_hit : first_hit);
		ev[`TCB_ST_SECOND] = !cascade && second_tick && second_hit;
		ev[`TCB_ST_WIDE] = wide_tick && (sel_reg ? wide_top : wide_hit);
		ev[`TCB_ST_CAPA] = cap_take[0];
		ev[`TCB_ST_CAPB] = cap_take[1];
		status_next = status_reg;
		if (rd_in && addr_in == `TCB_ADDR_STATUS)
			status_next = '0;
		status_next = status_next | ev; // R13 R17
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			status_reg <= '0;
		else
			status_reg <= status_next;
	end

	assign irq_out = |(status_reg & mask_reg);

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata_next = 8'h00;
		unique case (addr_in)
			`TCB_ADDR_FIRST_CNT: rdata_next = first_cnt_reg;
			`TCB_ADDR_SECOND_CNT: rdata_next = second_cnt_reg;
			`TCB_ADDR_FIRST_PER: rdata_next = first_per_reg;
			`TCB_ADDR_SECOND_PER: rdata_next = second_per_reg;
			`TCB_ADDR_WIDE_LO: rdata_next = wide_cnt_reg[7:0];
			`TCB_ADDR_WIDE_HI: rdata_next = wide_cnt_reg[15:8];
			`TCB_ADDR_CTRL: rdata_next = ctrl_reg;
			`TCB_ADDR_CTRL2:
			begin
				rdata_next[`TCB_CTRL2_SEL] = sel_reg;
				rdata_next[`TCB_CTRL2_OVR_LSB +: 2] = ovr_reg;
			end
			`TCB_ADDR_PCA_LO: rdata_next = pc_reg[0][7:0];
			`TCB_ADDR_PCA_HI: rdata_next = pc_reg[0][15:8];
			`TCB_ADDR_CAPB_LO: rdata_next = pc_reg[1][7:0];
			`TCB_ADDR_CAPB_HI: rdata_next = pc_reg[1][15:8];
			`TCB_ADDR_STATUS: rdata_next[`TCB_ST_W-1:0] = status_reg;
			`TCB_ADDR_MASK: rdata_next[`TCB_ST_W-1:0] = mask_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			rdata_reg <= 8'h00;
		else if (rd_in)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= 8'h00;
	end

	assign rdata_out = rdata_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	first_wrap_a: assert property ( // R17
		!cascade && first_tick && first_hit && !wr_in
		|=> first_cnt_reg == 8'h00 && status_reg[`TCB_ST_FIRST])
		else $error("first timer did not wrap at period");

	first_inc_a: assert property ( // R01
		!cascade && first_tick && !first_hit && !wr_in
		|=> first_cnt_reg == $past(first_cnt_reg) + 8'h01)
		else $error("first timer did not increment");

	int_src_a: assert property ( // R02
		!ctrl_reg[`TCB_CTRL_SECOND_SRC] && !cascade && !second_hit && !wr_in
		|=> second_cnt_reg != $past(second_cnt_reg))
		else $error("internal source did not count");

	cascade_hold_a: assert property ( // R06
		cascade && !wr_in && first_cnt_reg != 8'hff && !casc_hit
		|=> $stable(second_cnt_reg))
		else $error("cascade high half moved without carry");

	wide_wrap_a: assert property ( // R13
		!sel_reg && wide_tick && wide_hit && !wr_in
		|=> wide_cnt_reg == 16'h0000 && status_reg[`TCB_ST_WIDE])
		else $error("wide timer did not wrap at period");

	cap_take_a: assert property ( // R09
		cap_take[1] |=> pc_reg[1] == $past(wide_cnt_reg) && full_reg[1])
		else $error("capture did not store the wide count");

	cap_keep_a: assert property ( // R15
		cap_ev[1] && full_reg[1] && !cap_done[1]
		|=> $stable(pc_reg[1]) && pend_reg[1])
		else $error("unread capture overwritten");

	cap_a_off_a: assert property ( // R14
		!sel_reg && !$past(sel_reg) |-> !$rose(status_reg[`TCB_ST_CAPA]))
		else $error("first capture flagged in period mode");

	ovr_move_a: assert property ( // R15
		cap_done[1] |=> ovr_reg[1] == $past(pend_reg[1]) && !pend_reg[1])
		else $error("overrun flag not transferred");

	read_data_a: assert property (
		rd_in && addr_in == `TCB_ADDR_CTRL |=> rdata_out == $past(ctrl_reg))
		else $error("read data wrong or late");

	cascade_wrap_c: cover property (cascade && first_tick && casc_hit);
	cap_b_ovr_c: cover property (cap_done[1] && pend_reg[1]);
	cap_a_take_c: cover property (cap_take[0]);
	irq_c: cover property ($rose(irq_out));

endmodule : tcb_timer_top
`default_nettype wire

//--- tcb_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module tcb_pin_model
(
	input wire logic clk_in,
	output logic shared_clk_out,
	output logic wide_clk_out,
	output logic [1:0] cap_out
);
	// ------------------------------------------------------------
	// external clock and capture pins
	// ------------------------------------------------------------
	// index 0 shared clock, 1 wide clock, 2 capture a, 3 capture b
	logic [3:0] pin_reg;
	int hold;

	assign shared_clk_out = pin_reg[0];
	assign wide_clk_out = pin_reg[1];
	assign cap_out = pin_reg[3:2];

	initial
	begin
		pin_reg = 4'hf;
		hold = 2;
	end

	task set_pin(input int idx, input logic lvl);
		@(posedge clk_in);
		pin_reg[idx] <= lvl;
	endtask : set_pin

	// each level lasts hold+1 cycles, never under three, so the
	// synchroniser cannot miss it; larger hold makes a slow source
	task pulse(input int idx, input int n);
		int i;
		for (i = 0; i < n; i++)
		begin
			set_pin(idx, 1'b0);
			repeat (hold) @(posedge clk_in);
			set_pin(idx, 1'b1);
			repeat (hold) @(posedge clk_in);
		end
		repeat (4) @(posedge clk_in);
	endtask : pulse

endmodule : tcb_pin_model

`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcb_consts.svh"

module testbench;
	logic clk_in;
	logic nrst_in;
	logic [7:0] addr_in;
	logic [7:0] wdata_in;
	logic wr_in;
	logic rd_in;
	logic [7:0] rdata_out;
	logic shared_pin;
	logic wide_pin;
	logic [1:0] cap_pin;
	logic irq_out;
	logic rd_pend;
	logic [7:0] exp_q[$];
	logic [7:0] msk_q[$];
	logic [7:0] adr_q[$];
	logic [7:0] e_v;
	logic [7:0] m_v;
	logic [7:0] a_v;
	logic [15:0] w;
	int errors;
	int checked;
	int cycles;
	int m;
	integer seed;

	tcb_timer_top u_tcb_timer_top (.clk_in(clk_in), .nrst_in(nrst_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out),
		.shared_ext_clock_pin_in(shared_pin),
		.wide_ext_clock_pin_in(wide_pin), .cap_pin_in(cap_pin),
		.irq_out(irq_out));

	tcb_pin_model u_tcb_pin_model (.clk_in(clk_in),
		.shared_clk_out(shared_pin), .wide_clk_out(wide_pin),
		.cap_out(cap_pin));

	// ------------------------------------------------------------
	// clock, bus tasks and result watcher
	// ------------------------------------------------------------
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	// the expected byte is queued as the strobe goes out
	task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		exp_q.push_back(e & mk);
		msk_q.push_back(mk);
		adr_q.push_back(a);
		@(posedge clk_in);
		rd_in <= 1'b0;
	endtask : rd

	task rd16(input logic [7:0] a, input logic [15:0] v);
		rd(a, v[7:0], 8'hff);
		rd(a + 8'h01, v[15:8], 8'hff);
	endtask : rd16

	task wide(input logic [15:0] v);
		wr(`TCB_ADDR_WIDE_LO, v[7:0]);
		wr(`TCB_ADDR_WIDE_HI, v[15:8]);
	endtask : wide

	task tdone(input string s);
		$display("test %s done", s);
	endtask : tdone

	task results;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	always @(posedge clk_in)
		rd_pend <= rd_in;

	// read data stand only in the cycle after the strobe
	always @(negedge clk_in)
	begin
		if (rd_pend === 1'b1 && exp_q.size() > 0)
		begin
			e_v = exp_q.pop_front();
			m_v = msk_q.pop_front();
			a_v = adr_q.pop_front();
			chk($sformatf("reg_%h", a_v), e_v, rdata_out & m_v);
		end
	end

	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			errors++;
			results();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		seed = 32'hf32ceccf;
		nrst_in = 1'b0;
		addr_in = 8'h00;
		wdata_in = 8'h00;
		wr_in = 1'b0;
		rd_in = 1'b0;
		rd_pend = 1'b0;
		errors = 0;
		checked = 0;
		cycles = 0;
		repeat (12) @(posedge clk_in);
		nrst_in <= 1'b1;
		u_tcb_pin_model.hold = 2 + int'($unsigned($random(seed)) % 4);
		rd(`TCB_ADDR_CTRL, 8'h00, 8'hff);
		rd16(`TCB_ADDR_PCA_LO, 16'hffff);
		rd(`TCB_ADDR_FIRST_PER, 8'hff, 8'hff);
		rd(`TCB_ADDR_SECOND_PER, 8'hff, 8'hff);
		rd(`TCB_ADDR_CTRL2, 8'h00, 8'hff);
		rd(`TCB_ADDR_STATUS, 8'h00, 8'hff);
		wr(8'h30, 8'h5a);
		rd(8'h30, 8'h00, 8'hff);
		tdone("reset");
		// internal source: about one count per clock, window 40..47
		wr(`TCB_ADDR_FIRST_CNT, 8'h3c);
		wr(`TCB_ADDR_SECOND_CNT, 8'h3c);
		wide(16'h003c);
		rd(`TCB_ADDR_FIRST_CNT, 8'h40, 8'hf8);
		rd(`TCB_ADDR_SECOND_CNT, 8'h40, 8'hf8);
		rd(`TCB_ADDR_WIDE_LO, 8'h40, 8'hf8);
		w = $random(seed);
		wr(`TCB_ADDR_CTRL, w[7:0]);
		rd(`TCB_ADDR_CTRL, w[7:0], 8'hff);
		wr(`TCB_ADDR_CTRL, 8'h07);
		rd(`TCB_ADDR_STATUS, 8'h00, 8'h00);
		tdone("internal");
		wr(`TCB_ADDR_FIRST_PER, 8'h04);
		wr(`TCB_ADDR_SECOND_PER, 8'h09);
		wr(`TCB_ADDR_FIRST_CNT, 8'h00);
		wr(`TCB_ADDR_SECOND_CNT, 8'h00);
		u_tcb_pin_model.pulse(0, 7);
		rd(`TCB_ADDR_FIRST_CNT, 8'h02, 8'hff);
		rd(`TCB_ADDR_SECOND_CNT, 8'h07, 8'hff);
		rd(`TCB_ADDR_STATUS, 8'h01, 8'hff);
		rd(`TCB_ADDR_STATUS, 8'h00, 8'hff);
		tdone("split");
		wr(`TCB_ADDR_CTRL, 8'h0f);
		wr(`TCB_ADDR_FIRST_PER, 8'hff);
		wr(`TCB_ADDR_SECOND_PER, 8'h01);
		wr(`TCB_ADDR_FIRST_CNT, 8'h00);
		wr(`TCB_ADDR_SECOND_CNT, 8'h00);
		u_tcb_pin_model.pulse(0, 260);
		rd(`TCB_ADDR_FIRST_CNT, 8'h04, 8'hff);
		rd(`TCB_ADDR_SECOND_CNT, 8'h01, 8'hff);
		rd(`TCB_ADDR_STATUS, 8'h00, 8'hff);
		u_tcb_pin_model.pulse(0, 252);
		rd16(`TCB_ADDR_FIRST_CNT, 16'h0000);
		rd(`TCB_ADDR_STATUS, 8'h01, 8'hff);
		tdone("cascade");
		wr(`TCB_ADDR_CTRL, 8'h07);
		wide(16'h5a00);
		wr(`TCB_ADDR_WIDE_LO, 8'h21);
		rd16(`TCB_ADDR_WIDE_LO, 16'h5a21);
		wr(`TCB_ADDR_PCA_LO, 8'h03);
		wr(`TCB_ADDR_PCA_HI, 8'h00);
		wide(16'h0000);
		u_tcb_pin_model.pulse(1, 5);
		rd16(`TCB_ADDR_WIDE_LO, 16'h0001);
		@(negedge clk_in);
		chk("irq_out", 8'h00, {7'h00, irq_out});
		wr(`TCB_ADDR_MASK, 8'h04);
		@(negedge clk_in);
		chk("irq_out", 8'h01, {7'h00, irq_out});
		rd(`TCB_ADDR_STATUS, 8'h04, 8'hff);
		@(negedge clk_in);
		chk("irq_out", 8'h00, {7'h00, irq_out});
		wr(`TCB_ADDR_MASK, 8'h00);
		tdone("wide");
		for (m = 0; m < 4; m++)
		begin
			wr(`TCB_ADDR_CTRL, {m[1:0], 6'h07});
			w = $random(seed);
			wide(w);
			if (m < 2)
			begin
				u_tcb_pin_model.set_pin(3, 1'b0);
				repeat (6) @(posedge clk_in);
				rd(`TCB_ADDR_STATUS, (m == 0) ? 8'h10 : 8'h00, 8'hff);
				u_tcb_pin_model.set_pin(3, 1'b1);
				repeat (6) @(posedge clk_in);
				rd(`TCB_ADDR_STATUS, (m == 1) ? 8'h10 : 8'h00, 8'hff);
			end
			else
			begin
				u_tcb_pin_model.pulse(3, (m == 2) ? 4 : 16);
				rd(`TCB_ADDR_STATUS, 8'h10, 8'hff);
			end
			rd16(`TCB_ADDR_CAPB_LO, w);
		end
		tdone("capture b modes");
		wr(`TCB_ADDR_CTRL, 8'h47);
		w = $random(seed);
		wide(w);
		u_tcb_pin_model.pulse(3, 1);
		wide(~w);
		u_tcb_pin_model.pulse(3, 1);
		rd16(`TCB_ADDR_CAPB_LO, w);
		rd(`TCB_ADDR_CTRL2, 8'h20, 8'hff);
		u_tcb_pin_model.pulse(3, 1);
		rd16(`TCB_ADDR_CAPB_LO, ~w);
		rd(`TCB_ADDR_CTRL2, 8'h00, 8'hff);
		rd(`TCB_ADDR_STATUS, 8'h10, 8'hff);
		tdone("overrun");
		wr(`TCB_ADDR_CTRL2, 8'h01);
		rd(`TCB_ADDR_CTRL2, 8'h01, 8'hff);
		for (m = 2; m < 4; m++)
		begin
			wr(`TCB_ADDR_CTRL, {2'b00, m[1:0], 4'h7});
			w = $random(seed);
			wide(w);
			// prescaler already at four when mode 11 starts
			u_tcb_pin_model.pulse(2, (m == 2) ? 3 : 11);
			rd(`TCB_ADDR_STATUS, 8'h00, 8'hff);
			u_tcb_pin_model.pulse(2, 1);
			rd(`TCB_ADDR_STATUS, 8'h08, 8'hff);
			rd16(`TCB_ADDR_PCA_LO, w);
		end
		wr(`TCB_ADDR_CTRL2, 8'h00);
		wr(`TCB_ADDR_CTRL, 8'h17);
		u_tcb_pin_model.pulse(2, 2);
		rd(`TCB_ADDR_STATUS, 8'h00, 8'hff);
		tdone("capture a");
		repeat (3) @(posedge clk_in);
		results();
	end

endmodule : testbench

`default_nettype wire
